// ### dai_top.sv
// Instruction-cycle counter with deferred-address interlocks
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/10ps
`include "dai_regs.svh"

module dai_top (
    input  logic        aclk,
    input  logic        aresetn,
    input  logic [7:0]  s_axi_awaddr,
    input  logic        s_axi_awvalid,
    output logic        s_axi_awready,
    input  logic [31:0] s_axi_wdata,
    input  logic [3:0]  s_axi_wstrb,
    input  logic        s_axi_wvalid,
    output logic        s_axi_wready,
    output logic [1:0]  s_axi_bresp,
    output logic        s_axi_bvalid,
    input  logic        s_axi_bready,
    input  logic [7:0]  s_axi_araddr,
    input  logic        s_axi_arvalid,
    output logic        s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0]  s_axi_rresp,
    output logic        s_axi_rvalid,
    input  logic        s_axi_rready,
    input  logic        buffer_busy_level,
    input  logic        change_sequence_level,
    input  logic        defined_instruction_level,
    input  logic        deferred_start_condition,
    input  logic        transfer_data_strobe,
    output logic        io_clock_pulse,
    output logic        io_select_pulse,
    output logic        memory_request,
    output logic        change_sequence_busy,
    output logic        instr_done
);

    dai_pkg::dai_state_t state_r;
    dai_pkg::dai_state_t state_nxt;

    logic        beta_r;
    logic        defer_pending_interlock;
    logic        memory_defer_interlock;
    logic        counter_role_select_bit;
    logic [31:0] instr_word_r;
    logic [1:0]  configuration_latch;
    logic        hold_latch;
    logic [5:0]  opcode_latch;
    logic [1:0]  idx_sel_r;
    logic [15:0] final_addr_r;
    logic [15:0] index_operand_r;
    logic [15:0] index_r [4];
    logic [31:0] mem_word_r;
    logic        mem_valid_r;
    logic        go_pend_r;
    logic        chg_pend_r;
    logic        ds_seen_r;
    logic        xfer_d_r;
    logic [4:0]  sync_q;
    logic        bb_s;
    logic        chg_s;
    logic        def_s;
    logic        dsc_s;
    logic        xfer_s;
    logic        io_done;
    logic        cnt_done;
    logic        ds_ran;
    logic        ultimate;
    logic        is_ios;
    logic        adv;
    logic        abandon;
    logic        finish;
    logic        ds_go;
    logic        cs_go;
    logic        io_start;
    logic        aw_hold_r;
    logic        w_hold_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        wr_fire;
    logic [31:0] rd_mux;
    logic        rd_hit;
    logic [31:0] idx_merge;

    // Byte-lane merge of a write into a register
    function automatic logic [31:0] dai_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                res[i*8 +: 8] = new_v[i*8 +: 8];
        return res;
    endfunction

    // Outside levels brought into the clock domain
    dai_sync #(
        .W (5)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({transfer_data_strobe, deferred_start_condition,
                   defined_instruction_level, change_sequence_level,
                   buffer_busy_level}),
        .q       (sync_q)
    );

    assign bb_s   = sync_q[0];
    assign chg_s  = sync_q[1];
    assign def_s  = sync_q[2];
    assign dsc_s  = sync_q[3];
    assign xfer_s = sync_q[4];

    assign io_start = io_clock_pulse | io_select_pulse | (xfer_s & ~xfer_d_r);

    // Settling timer after in-out pulses
    dai_timer u_io_settle (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (io_start),
        .done    (io_done)
    );

    dai_timer u_seq_cnt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (ds_go | cs_go),
        .done    (cnt_done)
    );

    assign ds_ran   = ds_seen_r & cnt_done;
    assign ultimate = defer_pending_interlock & ~memory_defer_interlock;
    assign is_ios   = (opcode_latch == `DAI_OP_IOS);

    // Next state of the instruction-cycle counter
    always_comb
    begin
        state_nxt = state_r;
        adv       = 1'b0;
        abandon   = 1'b0;
        finish    = 1'b0;
        ds_go     = 1'b0;
        unique case (state_r)
            dai_pkg::DAI_S00:
            begin
                if (defer_pending_interlock && memory_defer_interlock)
                    adv = dsc_s & ~change_sequence_busy;
                else if (defer_pending_interlock)
                    adv = ~change_sequence_busy;
                else
                    adv = go_pend_r & ~change_sequence_busy;
                state_nxt = dai_pkg::DAI_S01;
            end
            dai_pkg::DAI_S01:
            begin
                adv       = 1'b1;
                state_nxt = dai_pkg::DAI_S02;
                ds_go     = 1'b1;
            end
            dai_pkg::DAI_S02:
            begin
                adv = ds_ran;
                if (chg_s)
                begin
                    abandon   = ds_ran;
                    state_nxt = dai_pkg::DAI_S00;
                end
                else
                    state_nxt = dai_pkg::DAI_S11;
            end
            dai_pkg::DAI_S11:
            begin
                adv       = ultimate | mem_valid_r;
                state_nxt = dai_pkg::DAI_S12;
            end
            dai_pkg::DAI_S12:
            begin
                adv       = 1'b1;
                state_nxt = dai_pkg::DAI_S13;
            end
            dai_pkg::DAI_S13:
            begin
                adv       = 1'b1;
                state_nxt = dai_pkg::DAI_S14;
            end
            dai_pkg::DAI_S14:
            begin
                adv = 1'b1;
                if (defer_pending_interlock)
                    state_nxt = dai_pkg::DAI_S00;
                else
                    state_nxt = dai_pkg::DAI_S22;
            end
            dai_pkg::DAI_S22:
            begin
                adv = io_done;
                if (chg_s)
                begin
                    abandon   = io_done;
                    state_nxt = dai_pkg::DAI_S00;
                end
                else if (bb_s)
                begin
                    ds_go     = io_done;
                    state_nxt = dai_pkg::DAI_S23;
                end
                else
                    state_nxt = dai_pkg::DAI_S24;
            end
            dai_pkg::DAI_S23:
            begin
                adv = ds_ran & io_done;
                if (chg_s)
                begin
                    abandon   = adv;
                    state_nxt = dai_pkg::DAI_S00;
                end
                else if (bb_s)
                begin
                    ds_go = adv;
                    adv   = 1'b0;
                end
                else
                    state_nxt = dai_pkg::DAI_S24;
            end
            dai_pkg::DAI_S24:
            begin
                adv       = 1'b1;
                state_nxt = dai_pkg::DAI_S25;
            end
            dai_pkg::DAI_S25:
            begin
                adv       = 1'b1;
                state_nxt = dai_pkg::DAI_S26;
            end
            dai_pkg::DAI_S26:
            begin
                adv       = 1'b1;
                state_nxt = dai_pkg::DAI_S31;
            end
            dai_pkg::DAI_S31:
            begin
                adv       = io_done;
                finish    = io_done;
                state_nxt = dai_pkg::DAI_S00;
            end
            default:
                state_nxt = dai_pkg::DAI_S00;
        endcase
        ds_go   = ds_go & beta_r;
        abandon = abandon & beta_r;
        finish  = finish & beta_r;
        adv     = adv & beta_r;
    end

    assign cs_go = abandon | (finish & chg_pend_r);

    // Counter state and alpha/beta phase
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= dai_pkg::DAI_S00;
            beta_r  <= 1'b0;
        end
        else if (!beta_r)
            beta_r <= 1'b1;
        else if (adv)
        begin
            state_r <= state_nxt;
            beta_r  <= 1'b0;
        end
    end

    // Deferral interlocks
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            defer_pending_interlock <= 1'b0;
            memory_defer_interlock  <= 1'b0;
        end
        else if (!beta_r && state_r == dai_pkg::DAI_S13)
        begin
            if (ultimate)
                defer_pending_interlock <= 1'b0;
            else if (instr_word_r[`DAI_DEFER_BIT])
                defer_pending_interlock <= 1'b1;
        end
        else if (!beta_r && state_r == dai_pkg::DAI_S14
                 && defer_pending_interlock)
        begin
            memory_defer_interlock <= instr_word_r[`DAI_DEFER_BIT] & def_s;
        end
    end

    // Word register and original-instruction latches
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            instr_word_r        <= `DAI_WORD_RST;
            configuration_latch <= 2'h0;
            hold_latch          <= 1'b0;
            opcode_latch        <= 6'h00;
            idx_sel_r           <= 2'h0;
        end
        // latch word by beta of 11
        else if (beta_r && state_r == dai_pkg::DAI_S11
                 && !ultimate && mem_valid_r)
        begin
            instr_word_r <= mem_word_r;
            if (!defer_pending_interlock)
            begin
                configuration_latch <= mem_word_r[`DAI_CF_MSB:`DAI_CF_LSB];
                hold_latch          <= mem_word_r[`DAI_HOLD_BIT];
                opcode_latch        <= mem_word_r[`DAI_OP_MSB:`DAI_OP_LSB];
                idx_sel_r <= mem_word_r[`DAI_IDXSEL_MSB:`DAI_IDXSEL_LSB];
            end
        end
    end

    // Final address and index operand
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            final_addr_r    <= 16'h0000;
            index_operand_r <= 16'h0000;
        end
        else if (!beta_r && state_r == dai_pkg::DAI_S14
                 && !defer_pending_interlock)
        begin
            final_addr_r    <= instr_word_r[`DAI_ADDR_MSB:0]
                               + index_r[idx_sel_r];
            index_operand_r <= index_r[idx_sel_r];
        end
    end

    // In-out pulses and completion
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            io_clock_pulse  <= 1'b0;
            io_select_pulse <= 1'b0;
            instr_done      <= 1'b0;
            memory_request  <= 1'b0;
            xfer_d_r        <= 1'b0;
        end
        else
        begin
            // clock pulses at 01 and 12
            io_clock_pulse  <= !beta_r && (state_r == dai_pkg::DAI_S01
                                || state_r == dai_pkg::DAI_S12);
            io_select_pulse <= !beta_r && state_r == dai_pkg::DAI_S26
                               && is_ios;
            instr_done      <= finish;
            memory_request  <= state_r == dai_pkg::DAI_S11 && !ultimate
                               && !mem_valid_r;
            xfer_d_r        <= xfer_s;
        end
    end

    // Role bit, change-sequence pending and busy
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            counter_role_select_bit <= 1'b0;
            change_sequence_busy    <= 1'b0;
            chg_pend_r              <= 1'b0;
            ds_seen_r               <= 1'b0;
        end
        else
        begin
            if (ds_go)
            begin
                counter_role_select_bit <= 1'b1;
                ds_seen_r               <= 1'b1;
            end
            else if (cs_go)
            begin
                counter_role_select_bit <= 1'b0;
                ds_seen_r               <= 1'b0;
            end
            if (cs_go)
                change_sequence_busy <= 1'b1;
            else if (change_sequence_busy && cnt_done)
                change_sequence_busy <= 1'b0;
            if (!beta_r && state_r == dai_pkg::DAI_S24 && !is_ios && chg_s)
                chg_pend_r <= 1'b1;
            else if (finish && chg_s)
                chg_pend_r <= 1'b1;
            else if (cs_go)
                chg_pend_r <= 1'b0;
        end
    end

    assign wr_fire = aw_hold_r & w_hold_r & ~s_axi_bvalid;

    // Index write merged into the low half of a word
    assign idx_merge = dai_merge({16'h0000, index_r[awaddr_r[3:2]]},
                                 wdata_r, wstrb_r);

    // Software registers; software sets win over hardware clears
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            go_pend_r   <= 1'b0;
            mem_valid_r <= 1'b0;
            mem_word_r  <= `DAI_WORD_RST;
            for (int i = 0; i < 4; i++)
                index_r[i] <= 16'h0000;
        end
        else
        begin
            if (state_r == dai_pkg::DAI_S00 && adv
                && !defer_pending_interlock)
                go_pend_r <= 1'b0;
            if (beta_r && state_r == dai_pkg::DAI_S11 && !ultimate)
                mem_valid_r <= 1'b0;
            if (wr_fire)
            begin
                if (awaddr_r == `DAI_CTRL_OFS && wstrb_r[0] && wdata_r[0])
                    go_pend_r <= 1'b1;
                if (awaddr_r == `DAI_MEMDATA_OFS)
                begin
                    mem_word_r  <= dai_merge(mem_word_r, wdata_r, wstrb_r);
                    mem_valid_r <= 1'b1;
                end
                if (awaddr_r >= `DAI_INDEX0_OFS
                    && awaddr_r <= `DAI_INDEX3_OFS && awaddr_r[1:0] == 2'h0)
                    index_r[awaddr_r[3:2]] <= idx_merge[15:0];
            end
        end
    end

    // Write channels, taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DAI_OKAY;
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            awaddr_r      <= 8'h00;
            wdata_r       <= `DAI_WORD_RST;
            wstrb_r       <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_r      <= s_axi_awaddr;
                aw_hold_r     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                w_hold_r     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_r == `DAI_CTRL_OFS
                    || awaddr_r == `DAI_MEMDATA_OFS
                    || (awaddr_r >= `DAI_INDEX0_OFS
                        && awaddr_r <= `DAI_INDEX3_OFS
                        && awaddr_r[1:0] == 2'h0))
                    ? `DAI_OKAY : `DAI_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read decode
    always_comb
    begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (s_axi_araddr)
            `DAI_CTRL_OFS:    rd_mux = {31'h0, go_pend_r};
            `DAI_MEMDATA_OFS: rd_mux = mem_word_r;
            `DAI_STATUS_OFS:  rd_mux = {20'h0, 4'(state_r), beta_r,
                mem_valid_r, go_pend_r, change_sequence_busy,
                memory_request, counter_role_select_bit,
                memory_defer_interlock, defer_pending_interlock};
            `DAI_ADDROUT_OFS: rd_mux = {16'h0, final_addr_r};
            `DAI_IDXOP_OFS:   rd_mux = {16'h0, index_operand_r};
            `DAI_OPLATCH_OFS: rd_mux = {23'h0, configuration_latch,
                                        hold_latch, opcode_latch};
            8'h20, 8'h24, 8'h28, `DAI_INDEX3_OFS:
                rd_mux = {16'h0, index_r[s_axi_araddr[3:2]]};
            default:          rd_hit = 1'b0;
        endcase
    end

    // Read channel, answer one cycle after address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `DAI_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_hit ? `DAI_OKAY : `DAI_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // dai_top

// ### dai_regs.svh
// Offsets, word fields, reset values and timing counts of the interlock block
`ifndef DAI_REGS_SVH
`define DAI_REGS_SVH

// Register byte offsets
`define DAI_ADDR_W       8
`define DAI_CTRL_OFS     8'h00
`define DAI_MEMDATA_OFS  8'h04
`define DAI_STATUS_OFS   8'h08
`define DAI_ADDROUT_OFS  8'h0C
`define DAI_IDXOP_OFS    8'h10
`define DAI_OPLATCH_OFS  8'h14
`define DAI_INDEX0_OFS   8'h20
`define DAI_INDEX3_OFS   8'h2C

// Instruction word fields
`define DAI_ADDR_MSB     15
`define DAI_DEFER_BIT    17
`define DAI_IDXSEL_MSB   19
`define DAI_IDXSEL_LSB   18
`define DAI_HOLD_BIT     23
`define DAI_OP_MSB       29
`define DAI_OP_LSB       24
`define DAI_CF_MSB       31
`define DAI_CF_LSB       30
`define DAI_OP_IOS       6'h2A

// Reset values and response codes
`define DAI_WORD_RST     32'h0000_0000
`define DAI_OKAY         2'h0
`define DAI_SLVERR       2'h2

// Timing: settling time after in-out pulses
`define DAI_CLK_NS       50
`define DAI_SETTLE_NS    1600
`define DAI_SETTLE_CYC   ((`DAI_SETTLE_NS + `DAI_CLK_NS - 1) / `DAI_CLK_NS)
`define DAI_CNT_W        6

`endif

// ### dai_pkg.sv
// Types shared by the interlock block
package dai_pkg;

    // Instruction-cycle counter states
    typedef enum logic [3:0] {
        DAI_S00, DAI_S01, DAI_S02, DAI_S11, DAI_S12, DAI_S13, DAI_S14,
        DAI_S22, DAI_S23, DAI_S24, DAI_S25, DAI_S26, DAI_S31
    } dai_state_t;

endpackage

// ### dai_sync.sv
// Two-flop synchroniser for outside levels
`timescale 1ns/10ps
`include "dai_regs.svh"

module dai_sync #(
    parameter int W = 5
) (
    input  logic         aclk,
    input  logic         aresetn,
    input  logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    // First stage feeds only the second
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_r <= '0;
            q      <= '0;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule // dai_sync

// ### dai_timer.sv
// Down counter measuring one settling interval
`timescale 1ns/10ps
`include "dai_regs.svh"

module dai_timer (
    input  logic aclk,
    input  logic aresetn,
    input  logic start,
    output logic done
);

    logic [`DAI_CNT_W-1:0] cnt_r;

    // Load on start, count down to zero
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_r <= '0;
        else if (start)
            cnt_r <= `DAI_CNT_W'(`DAI_SETTLE_CYC);
        else if (cnt_r != '0)
            cnt_r <= cnt_r - `DAI_CNT_W'(1);
    end

    assign done = (cnt_r == '0);

endmodule // dai_timer

// ### dai_io_model.sv
// Behavioural in-out element and sequence selector levels
`timescale 1ns/10ps
module dai_io_model (
    input  logic       aclk,
    input  logic [1:0] req,
    output logic       buffer_busy_level,
    output logic       change_sequence_level,
    output logic       defined_instruction_level,
    output logic       deferred_start_condition,
    output logic       transfer_data_strobe
);
    // Every instruction defined, no data transfers
    initial
    begin
        defined_instruction_level = 1'b1;
        deferred_start_condition = 1'b0;
        transfer_data_strobe = 1'b0;
    end
    // start condition offered after random stalls
    // Bit 0 wants change of sequence, bit 1 holds buffer busy
    always @(posedge aclk)
    begin
        deferred_start_condition <= ($urandom % 4) != 0;
        change_sequence_level <= req[0];
        buffer_busy_level <= req[1];
    end
endmodule // dai_io_model

// ### dai_top_checker.sv
// Port-level checks of the interlock block
`timescale 1ns/10ps
module dai_top_checker (
    input logic        aclk, aresetn, s_axi_awvalid, s_axi_awready,
    input logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid,
    input logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input logic        s_axi_rready, io_clock_pulse, io_select_pulse,
    input logic        memory_request, instr_done,
    input logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_clk_pulse_one: assert property (io_clock_pulse |=> !io_clock_pulse)
        else $error("io clock pulse too long");
    a_clk_not_mem: assert property (io_clock_pulse |-> !memory_request)
        else $error("io clock pulse during memory wait");
    a_sel_pulse_one: assert property (io_select_pulse |=> !io_select_pulse)
        else $error("select pulse too long");
    a_sel_not_clk: assert property (io_select_pulse |-> !io_clock_pulse)
        else $error("select and clock pulses together");
    a_sel_settle: assert property (io_select_pulse |=> !instr_done [*8])
        else $error("done before settling after select");
    a_done_one: assert property (instr_done |=> !instr_done)
        else $error("done pulse too long");
    a_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready
        |-> ##[1:2] s_axi_rvalid) else $error("read response late");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
endmodule // dai_top_checker
bind dai_top dai_top_checker chk_u (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .io_clock_pulse, .io_select_pulse, .memory_request, .instr_done,
    .s_axi_rdata);

// ### deferred_address_interlock_control_tb.sv
// Self-checking bench for deferred address sequencing
`timescale 1ns/10ps
module deferred_address_interlock_control_tb;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdw, rd, idx, w1, w2;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, awr, wr_r, bv, arr, rv;
    logic        bb, cs, di, ds, ts, mreq, done, csb;
    logic [1:0]  rr, rrw, br, brr, req = 0;
    int          miscompares = 0, total_checks = 0, n;
    always #25 aclk = ~aclk;
    dai_io_model io_u (.aclk, .req, .buffer_busy_level(bb),
        .change_sequence_level(cs), .defined_instruction_level(di),
        .deferred_start_condition(ds), .transfer_data_strobe(ts));
    dai_top dut_u (.aclk, .aresetn, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awr), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wr_r),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arr),
        .s_axi_rdata(rdw), .s_axi_rresp(rrw), .s_axi_rvalid(rv),
        .s_axi_rready(rready), .buffer_busy_level(bb),
        .change_sequence_level(cs), .defined_instruction_level(di),
        .deferred_start_condition(ds), .transfer_data_strobe(ts),
        .io_clock_pulse(), .io_select_pulse(), .memory_request(mreq),
        .change_sequence_busy(csb), .instr_done(done));
    // Verdict and end of run
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic hang;
        miscompares++;
        close_out;
    endtask
    // Write one word, both channels offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awvalid && awr) awvalid <= 0;
            if (wvalid && wr_r) wvalid <= 0;
            if (bv) break;
        end
        brr = br;
        bready <= 0;
        if (n == 50) hang;
    endtask
    // Read one word
    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arvalid && arr) arvalid <= 0;
            if (rv) break;
        end
        rd = rdw; rr = rrw; rready <= 0;
        if (n == 50) hang;
    endtask
    // Wait: 0 memory request, 1 request gone, 2 done, 3 busy
    task automatic wt(input int k);
        for (n = 0; n < 3000; n++)
        begin
            @(posedge aclk);
            if ((k == 0 && mreq === 1'b1) || (k == 1 && mreq === 1'b0) ||
                (k == 2 && done === 1'b1) || (k == 3 && csb === 1'b1))
                return;
        end
        hang;
    endtask
    initial
    begin
        n = $urandom(32'h95764C30);
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        // Plain select instruction, no deferral
        wr(8'h00, 1); wt(0);
        wr(8'h04, 32'h2A00_0000 | ($urandom & 32'hFFFF)); wt(2);
        rdr(8'h08); chk("interlocks", 0, rd & 3);
        // Two-level deferral through index register 2
        idx = $urandom & 32'hFFFF; w1 = $urandom; w2 = $urandom;
        w1[17] = 1; w1[19:18] = 2; w1[29] = 0; w2[17] = 0;
        wr(8'h28, idx); wr(8'h00, 1); wt(0); wr(8'h04, w1); wt(1); wt(0);
        rdr(8'h08); chk("pending", 3, rd & 3);
        wr(8'h04, w2); wt(2);
        rdr(8'h0C); chk("addr", (w2 + idx) & 16'hFFFF, rd & 16'hFFFF);
        rdr(8'h10); chk("index op", idx, rd & 16'hFFFF);
        rdr(8'h14);
        chk("op", {w1[31:30], w1[23], w1[29:24]}, rd & 9'h1FF);
        rdr(8'h08); chk("cleared", 0, rd & 3);
        rdr(8'hFC); chk("unmapped", 2, rr);
        wr(8'hFC, 1);
        chk("wr unmapped", 2, brr);
        // Change of sequence wanted: pass abandoned after sync cycle
        req <= 1;
        wr(8'h00, 1);
        wt(3);
        rdr(8'h08);
        chk("abandon", 32'h0010, rd & 32'h0F14);
        // Buffer busy keeps the counter waiting in 23
        req <= 2;
        wr(8'h00, 1);
        wt(0);
        wr(8'h04, w2);
        repeat (300) @(posedge aclk);
        rdr(8'h08);
        chk("busy wait", 8, rd[11:8]);
        req <= 0;
        wt(2);
        close_out;
    end
endmodule // deferred_address_interlock_control_tb
